// ---- tmds_switch_config_regs_bench.sv ----
// Self-checking bench for the link switch configuration register bank
`timescale 1ns/100ps
module tmds_switch_config_regs_bench;
	logic                  clock_in;      // 10 MHz clock
	logic                  reset_in;      // Active high reset
	tsw_pkg::tsw_reg_req_t req;           // Register access strobe bundle
	logic [7:0]            rdata;         // Read data from the bank
	tsw_pkg::tsw_strap_t   tie;           // Which strap pins sit on the rail
	tsw_pkg::tsw_strap_t   strap;         // Pin levels from the board model
	tsw_pkg::tsw_cfg_t     cfg;           // Decoded settings
	logic [3:0]            term_conn [4]; // Effective terminations per source
	logic [3:0]            eq_high [4];   // Equaliser level per source
	logic                  serial_mode;   // Serial control has taken over
	logic [7:0]            rd_v;          // Value returned by a read
	int                    mismatches;    // Wrong values seen
	int                    n_checks;      // Comparisons made

	////////////////////////////////////////////////////////////////////////////////
	tsw_strap_board board_u (.rail_high_in(tie), .strap_out(strap));
	tsw_config_regs dut_u (.clock_in(clock_in), .reset_in(reset_in), .reg_req_in(req),
		.reg_rdata_out(rdata), .strap_in(strap), .cfg_out(cfg),
		.term_connect_out(term_conn), .eq_high_out(eq_high), .serial_mode_out(serial_mode));

	// Clock generator, 100 ns period
	initial begin
		clock_in = 1'h0;
		forever #50 clock_in = ~clock_in;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Compare one value and count it
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		if (seen !== exp) begin
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
			mismatches++;
		end
		n_checks++;
	endtask : chk

	// Print the verdict and stop
	task automatic end_of_test;
		if (mismatches == 0 && n_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : end_of_test

	// One write strobe; the effect is sampled once the next edge has landed
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock_in);
		req <= '{1'h1, 1'h0, a, d};
		@(posedge clock_in);
		req <= '0;
		@(posedge clock_in);
		#1;
	endtask : wr

	// One read strobe; read data holds until the next read
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock_in);
		req <= '{1'h0, 1'h1, a, 8'h00};
		@(posedge clock_in);
		req <= '0;
		@(posedge clock_in);
		#1;
		d = rdata;
	endtask : rd

	// Short reset pulse, then time for the straps to pass the synchroniser
	task automatic reset_pulse;
		@(posedge clock_in);
		reset_in <= 1'h1;
		repeat (2) @(posedge clock_in);
		reset_in <= 1'h0;
		repeat (6) @(posedge clock_in);
		#1;
	endtask : reset_pulse

	// Expected per-source nibble: A from bit 4 up, B from bit 0 up, C and D reversed
	function automatic logic [3:0] pick(input logic [15:0] v, input int s);
		logic [3:0] r;
		for (int c = 0; c < 4; c++) begin
			case (s)
				0: r[c] = v[4+c];
				1: r[c] = v[c];
				2: r[c] = v[11-c];
				default: r[c] = v[15-c];
			endcase
		end
		return r;
	endfunction : pick

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		mismatches = 0;
		n_checks = 0;
		reset_in = 1'h1;
		req = '0;
		tie = '{1'h1, 2'h2, 1'h1, 2'h1, 1'h0, 1'h1};
		repeat (20) @(posedge clock_in);
		reset_in <= 1'h0;
		repeat (6) @(posedge clock_in);
		#1;
		// Strap image before any access
		chk(cfg.fast_switch_enable, 16'h1);
		chk(cfg.fast_source_select, 16'h2);
		chk(cfg.aux_switch_enable, 16'h1);
		chk(cfg.aux_source_select, 16'h2);
		chk(cfg.input_eq_select_vec, 16'hFFFF);
		chk({cfg.output_preemph_level, cfg.output_term_on, cfg.output_current_high}, 16'h5);
		chk(serial_mode, 16'h0);
		chk(cfg.input_term_master_on, 16'h1);
		for (int s = 0; s < 4; s++) begin
			chk(term_conn[s], 16'h0);
			chk(eq_high[s], 16'hF);
		end
		// Every select code, enable toggled, reset after each change
		for (int s = 0; s < 4; s++) begin
			tie.strap_source_select <= s[1:0];
			tie.strap_switch_enable <= s[0];
			reset_pulse();
			chk(cfg.fast_source_select, 16'(s));
			chk(cfg.aux_source_select, 16'(s));
			chk(cfg.fast_switch_enable, 16'(s % 2));
		end
		// First access hands control to the serial side
		wr(tsw_pkg::ADDR_TX_SETTINGS, 8'h0E);
		chk(serial_mode, 16'h1);
		tie <= '0;
		repeat (6) @(posedge clock_in);
		#1;
		chk(cfg.fast_source_select, 16'h3);
		chk(cfg.output_preemph_level, 16'h3);
		// Every pre-emphasis code once, termination from its low bit and current from its high bit
		for (int p = 0; p < 4; p++) begin
			wr(tsw_pkg::ADDR_TX_SETTINGS, {4'h0, 2'(p), 1'(p), 1'(p >> 1)});
			chk(cfg.output_preemph_level, 16'(p));
			chk(cfg.output_term_on, 16'(p % 2));
			chk(cfg.output_current_high, 16'(p / 2));
		end
		// Mode registers written serially: standby with source B, then aux on source D
		wr(tsw_pkg::ADDR_FAST_MODES, 8'h01);
		chk(cfg.fast_switch_enable, 16'h0);
		chk(cfg.fast_source_select, 16'h1);
		wr(tsw_pkg::ADDR_AUX_MODES, 8'h43);
		chk(cfg.aux_switch_enable, 16'h1);
		chk(cfg.aux_source_select, 16'h3);
		// Termination and equaliser vectors across their two bytes
		wr(tsw_pkg::ADDR_RX_SETTINGS, 8'h01);
		wr(tsw_pkg::ADDR_TERM_LOW, 8'hA5);
		wr(tsw_pkg::ADDR_TERM_HIGH, 8'h3C);
		wr(tsw_pkg::ADDR_EQ_LOW, 8'h5A);
		wr(tsw_pkg::ADDR_EQ_HIGH, 8'hC3);
		chk(cfg.input_term_select_vec, 16'h3CA5);
		chk(cfg.input_eq_select_vec, 16'hC35A);
		for (int s = 0; s < 4; s++) begin
			chk(term_conn[s], pick(16'h3CA5, s));
			chk(eq_high[s], pick(16'hC35A, s));
		end
		// Master off opens every input termination
		wr(tsw_pkg::ADDR_RX_SETTINGS, 8'h00);
		chk(cfg.input_term_master_on, 16'h0);
		for (int s = 0; s < 4; s++) chk(term_conn[s], 16'h0);
		// Read back, with an unmapped place between the mapped ones
		rd(tsw_pkg::ADDR_TERM_HIGH, rd_v);
		chk(rd_v, 16'h3C);
		rd(tsw_pkg::ADDR_EQ_LOW, rd_v);
		chk(rd_v, 16'h5A);
		rd(8'h05, rd_v);
		chk(rd_v, 16'h00);
		rd(tsw_pkg::ADDR_TX_SETTINGS, rd_v);
		chk(rd_v, 16'h0F);
		rd(tsw_pkg::ADDR_FAST_MODES, rd_v);
		chk(rd_v, 16'h01);
		// Reset returns the bank to strap control with terminations open
		reset_pulse();
		chk(serial_mode, 16'h0);
		chk(cfg.input_term_select_vec, 16'h0);
		// A read alone ends strap mode; later strap changes are ignored
		rd(tsw_pkg::ADDR_AUX_MODES, rd_v);
		chk(rd_v, 16'h40);
		chk(serial_mode, 16'h1);
		tie <= '{1'h1, 2'h3, 1'h1, 2'h3, 1'h1, 1'h1};
		repeat (6) @(posedge clock_in);
		#1;
		chk(cfg.fast_source_select, 16'h0);
		chk(cfg.fast_switch_enable, 16'h0);
		end_of_test();
	end
endmodule : tmds_switch_config_regs_bench

// ---- tsw_config_regs.sv ----
// Configuration register bank of the four-input link switch
`timescale 1ns/100ps
module tsw_config_regs (
	input  wire logic                  clock_in,
	input  wire logic                  reset_in,
	input  wire tsw_pkg::tsw_reg_req_t reg_req_in,
	output logic               [7:0]   reg_rdata_out,
	input  wire tsw_pkg::tsw_strap_t   strap_in,
	output tsw_pkg::tsw_cfg_t          cfg_out,
	output logic               [3:0]   term_connect_out [4],
	output logic               [3:0]   eq_high_out [4],
	output logic                       serial_mode_out
);

	////////////////////////////////////////////////////////////////////////
	// Declarations
	tsw_pkg::tsw_strap_t strap_s;           // Synchronised straps
	tsw_pkg::tsw_mode_t  mode_q, mode_d;    // Strap or serial control
	logic [7:0]  fast_q, fast_d;            // Fast path mode register
	logic [7:0]  aux_q, aux_d;              // Auxiliary mode register
	logic [7:0]  rxs_q, rxs_d;              // Receiver settings
	logic [15:0] term_q, term_d;            // Termination vector
	logic [15:0] eq_q, eq_d;                // Equalizer vector
	logic [7:0]  tx_q, tx_d;                // Transmitter settings
	logic [7:0]  rdata_q, rdata_d;          // Registered read data
	logic        access;                    // Any serial access this cycle
	logic [15:0] term_eff;                  // Terminations after master gate

	////////////////////////////////////////////////////////////////////////
	// Straps are board pins, so they cross into the clock domain first
	tsw_sync #(
		.WIDTH ($bits(tsw_pkg::tsw_strap_t))
	) u_strap_sync (
		.clock_in (clock_in),
		.reset_in (reset_in),
		.async_in (strap_in),
		.sync_out (strap_s)
	);

	assign access = reg_req_in.write | reg_req_in.read;

	////////////////////////////////////////////////////////////////////////
	// Mode flag: once serial, stays serial until the next reset
	always_comb begin
		mode_d = mode_q;
		if (access) begin
			mode_d = tsw_pkg::TSW_MODE_SERIAL;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register next values: strap copy, serial write, or hold
	always_comb begin
		fast_d = fast_q;
		aux_d  = aux_q;
		rxs_d  = rxs_q;
		term_d = term_q;
		eq_d   = eq_q;
		tx_d   = tx_q;
		if (mode_q == tsw_pkg::TSW_MODE_STRAP && !access) begin
			// Pin levels are taken as-is: high is one, low is zero
			fast_d = {1'h0, strap_s.strap_switch_enable, 4'h0,
				strap_s.strap_source_select};
			aux_d  = {1'h0, 1'h1, 4'h0, strap_s.strap_source_select};
			// Master bit reads one, but the termination vector stays clear
			rxs_d  = tsw_pkg::RST_RX_SETTINGS;
			term_d = 16'h0000;
			eq_d   = {16{strap_s.strap_eq_high}};
			tx_d   = {4'h0, strap_s.strap_preemph_level,
				strap_s.strap_output_term_on,
				strap_s.strap_output_current_high};
		end else if (reg_req_in.write) begin
			// Writes win in the access cycle; serial control takes over
			if (reg_req_in.addr == tsw_pkg::ADDR_FAST_MODES) begin
				fast_d = reg_req_in.wdata;
			end else if (reg_req_in.addr == tsw_pkg::ADDR_AUX_MODES) begin
				aux_d = reg_req_in.wdata;
			end else if (reg_req_in.addr == tsw_pkg::ADDR_RX_SETTINGS) begin
				rxs_d = reg_req_in.wdata;
			end else if (reg_req_in.addr == tsw_pkg::ADDR_TERM_LOW) begin
				term_d[7:0] = reg_req_in.wdata;
			end else if (reg_req_in.addr == tsw_pkg::ADDR_TERM_HIGH) begin
				term_d[15:8] = reg_req_in.wdata;
			end else if (reg_req_in.addr == tsw_pkg::ADDR_EQ_LOW) begin
				eq_d[7:0] = reg_req_in.wdata;
			end else if (reg_req_in.addr == tsw_pkg::ADDR_EQ_HIGH) begin
				eq_d[15:8] = reg_req_in.wdata;
			end else if (reg_req_in.addr == tsw_pkg::ADDR_TX_SETTINGS) begin
				tx_d = reg_req_in.wdata;
			end
			// Unmapped addresses: write ignored
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read data: captured on a read, held otherwise
	always_comb begin
		rdata_d = rdata_q;
		if (reg_req_in.read) begin
			if (reg_req_in.addr == tsw_pkg::ADDR_FAST_MODES) begin
				rdata_d = fast_q;
			end else if (reg_req_in.addr == tsw_pkg::ADDR_AUX_MODES) begin
				rdata_d = aux_q;
			end else if (reg_req_in.addr == tsw_pkg::ADDR_RX_SETTINGS) begin
				rdata_d = rxs_q;
			end else if (reg_req_in.addr == tsw_pkg::ADDR_TERM_LOW) begin
				rdata_d = term_q[7:0];
			end else if (reg_req_in.addr == tsw_pkg::ADDR_TERM_HIGH) begin
				rdata_d = term_q[15:8];
			end else if (reg_req_in.addr == tsw_pkg::ADDR_EQ_LOW) begin
				rdata_d = eq_q[7:0];
			end else if (reg_req_in.addr == tsw_pkg::ADDR_EQ_HIGH) begin
				rdata_d = eq_q[15:8];
			end else if (reg_req_in.addr == tsw_pkg::ADDR_TX_SETTINGS) begin
				rdata_d = tx_q;
			end else begin
				rdata_d = 8'h00;  // Unmapped reads return zero
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// All state registers
	always_ff @(posedge clock_in or posedge reset_in) begin
		if (reset_in) begin
			mode_q  <= tsw_pkg::TSW_MODE_STRAP;
			fast_q  <= tsw_pkg::RST_FAST_MODES;
			aux_q   <= tsw_pkg::RST_AUX_MODES;
			rxs_q   <= tsw_pkg::RST_RX_SETTINGS;
			term_q  <= {tsw_pkg::RST_TERM, tsw_pkg::RST_TERM};
			eq_q    <= {tsw_pkg::RST_EQ, tsw_pkg::RST_EQ};
			tx_q    <= tsw_pkg::RST_TX_SETTINGS;
			rdata_q <= 8'h00;
		end else begin
			mode_q  <= mode_d;
			fast_q  <= fast_d;
			aux_q   <= aux_d;
			rxs_q   <= rxs_d;
			term_q  <= term_d;
			eq_q    <= eq_d;
			tx_q    <= tx_d;
			rdata_q <= rdata_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Settings to the analog side, decoded straight from the registers
	// Master bit clear opens every input termination whatever the vector says
	assign term_eff = term_q & {16{rxs_q[tsw_pkg::RX_MASTER_BIT]}};

	always_comb begin
		cfg_out.fast_switch_enable    = fast_q[tsw_pkg::MODE_EN_BIT];
		cfg_out.fast_source_select    = fast_q[tsw_pkg::MODE_SEL_MSB:0];
		cfg_out.aux_switch_enable     = aux_q[tsw_pkg::MODE_EN_BIT];
		cfg_out.aux_source_select     = aux_q[tsw_pkg::MODE_SEL_MSB:0];
		cfg_out.input_term_master_on  = rxs_q[tsw_pkg::RX_MASTER_BIT];
		cfg_out.input_term_select_vec = term_q;
		cfg_out.input_eq_select_vec   = eq_q;
		cfg_out.output_preemph_level  = tx_q[tsw_pkg::OUTPUT_PREEMPH_LEVEL_MSB:tsw_pkg::OUTPUT_PREEMPH_LEVEL_LSB];
		cfg_out.output_term_on        = tx_q[tsw_pkg::TX_OTO_BIT];
		cfg_out.output_current_high   = tx_q[tsw_pkg::OUTPUT_CURRENT_HIGH_BIT];
	end

	// Per source (0=A .. 3=D) and channel: A and B ascend, C and D descend
	for (genvar g = 0; g < 16; g++) begin : g_chan
		localparam int SRC  = g / 4;
		localparam int CH   = g % 4;
		localparam int BIT  = (SRC == 0) ? tsw_pkg::SRC_A_BASE + CH :
			(SRC == 1) ? tsw_pkg::SRC_B_BASE + CH :
			(SRC == 2) ? tsw_pkg::SRC_C_BASE + 3 - CH :
			tsw_pkg::SRC_D_BASE + 3 - CH;
		assign term_connect_out[SRC][CH] = term_eff[BIT];
		assign eq_high_out[SRC][CH]      = eq_q[BIT];
	end

	assign reg_rdata_out   = rdata_q;
	assign serial_mode_out = (mode_q == tsw_pkg::TSW_MODE_SERIAL);

	////////////////////////////////////////////////////////////////////////
	// Checks
	logic strap_load;
	assign strap_load = (mode_q == tsw_pkg::TSW_MODE_STRAP) && !access;

	// The release edge itself still holds reset values, so it is left out
	chk_strap_fast: assert property (@(posedge clock_in) disable iff (reset_in)
		strap_load && !reset_in |=> fast_q == {1'h0, $past(strap_s.strap_switch_enable),
			4'h0, $past(strap_s.strap_source_select)})
		else $error("fast modes not loaded from straps");

	chk_strap_aux: assert property (@(posedge clock_in) disable iff (reset_in)
		strap_load |=> aux_q[6] && aux_q[1:0] == fast_q[1:0])
		else $error("aux modes not forced in strap mode");

	chk_strap_term_off: assert property (@(posedge clock_in) disable iff (reset_in)
		strap_load |=> term_eff == 16'h0000)
		else $error("input termination on in strap mode");

	chk_strap_eq_all: assert property (@(posedge clock_in) disable iff (reset_in)
		strap_load |=> eq_q == {16{$past(strap_s.strap_eq_high)}})
		else $error("equalizer not copied from strap");

	chk_mode_first_access: assert property (@(posedge clock_in) disable iff (reset_in)
		access |=> serial_mode_out ##1 serial_mode_out)
		else $error("mode flag not set by access");

	chk_serial_keeps: assert property (@(posedge clock_in) disable iff (reset_in)
		serial_mode_out && !reg_req_in.write |=> $stable(tx_q) && $stable(fast_q))
		else $error("serial settings changed without a write");

	chk_tx_write: assert property (@(posedge clock_in) disable iff (reset_in)
		reg_req_in.write && reg_req_in.addr == tsw_pkg::ADDR_TX_SETTINGS |=>
		cfg_out.output_preemph_level == $past(reg_req_in.wdata[3:2]) &&
		cfg_out.output_term_on == $past(reg_req_in.wdata[1]) &&
		cfg_out.output_current_high == $past(reg_req_in.wdata[0]))
		else $error("transmitter write not applied");

	chk_term_map: assert property (@(posedge clock_in) disable iff (reset_in)
		reg_req_in.write && reg_req_in.addr == tsw_pkg::ADDR_TERM_HIGH &&
		rxs_q[0] && !(mode_q == tsw_pkg::TSW_MODE_STRAP) |=>
		term_connect_out[2][0] == $past(reg_req_in.wdata[3]) &&
		term_connect_out[3][3] == $past(reg_req_in.wdata[4]))
		else $error("termination high byte mis-mapped");

	chk_read_back: assert property (@(posedge clock_in) disable iff (reset_in)
		reg_req_in.read && !reg_req_in.write &&
		reg_req_in.addr == tsw_pkg::ADDR_EQ_LOW |=> reg_rdata_out == $past(eq_q[7:0]))
		else $error("read data wrong");

	cov_strap_load: cover property (@(posedge clock_in) disable iff (reset_in)
		strap_load ##1 strap_load);
	cov_first_write: cover property (@(posedge clock_in) disable iff (reset_in)
		!serial_mode_out && reg_req_in.write);
	cov_term_on: cover property (@(posedge clock_in) disable iff (reset_in)
		term_eff != 16'h0000);
	cov_tx_read: cover property (@(posedge clock_in) disable iff (reset_in)
		reg_req_in.read && reg_req_in.addr == tsw_pkg::ADDR_TX_SETTINGS);

endmodule : tsw_config_regs

// ---- tsw_pkg.sv ----
// Shared constants and carrier types for the link switch configuration bank
package tsw_pkg;

	// Register offsets of the serial register map
	localparam logic [7:0] ADDR_FAST_MODES  = 8'h00;
	localparam logic [7:0] ADDR_AUX_MODES   = 8'h01;
	localparam logic [7:0] ADDR_RX_SETTINGS = 8'h10;
	localparam logic [7:0] ADDR_TERM_LOW    = 8'h11;
	localparam logic [7:0] ADDR_TERM_HIGH   = 8'h12;
	localparam logic [7:0] ADDR_EQ_LOW      = 8'h13;
	localparam logic [7:0] ADDR_EQ_HIGH     = 8'h14;
	localparam logic [7:0] ADDR_TX_SETTINGS = 8'h20;

	// Reset values
	localparam logic [7:0] RST_FAST_MODES  = 8'h40;
	localparam logic [7:0] RST_AUX_MODES   = 8'h40;
	localparam logic [7:0] RST_RX_SETTINGS = 8'h01;
	localparam logic [7:0] RST_TERM        = 8'h00;
	localparam logic [7:0] RST_EQ          = 8'h00;
	localparam logic [7:0] RST_TX_SETTINGS = 8'h03;

	// Field positions
	localparam int MODE_EN_BIT     = 6;
	localparam int MODE_SEL_MSB    = 1;
	localparam int RX_MASTER_BIT   = 0;
	localparam int OUTPUT_PREEMPH_LEVEL_MSB       = 3;
	localparam int OUTPUT_PREEMPH_LEVEL_LSB       = 2;
	localparam int TX_OTO_BIT      = 1;
	localparam int OUTPUT_CURRENT_HIGH_BIT      = 0;

	// Per-source offsets into the 16-bit channel vectors
	localparam int SRC_A_BASE = 4;
	localparam int SRC_B_BASE = 0;
	localparam int SRC_C_BASE = 8;
	localparam int SRC_D_BASE = 12;

	// Register mode: strap control or serial control
	typedef enum logic {
		TSW_MODE_STRAP  = 1'h0,
		TSW_MODE_SERIAL = 1'h1
	} tsw_mode_t;

	// One serial register access from the protocol engine
	typedef struct packed {
		logic       write;
		logic       read;
		logic [7:0] addr;
		logic [7:0] wdata;
	} tsw_reg_req_t;

	// Board strap pins
	typedef struct packed {
		logic       strap_switch_enable;
		logic [1:0] strap_source_select;
		logic       strap_eq_high;
		logic [1:0] strap_preemph_level;
		logic       strap_output_term_on;
		logic       strap_output_current_high;
	} tsw_strap_t;

	// Settings that steer the analog circuits
	typedef struct packed {
		logic        fast_switch_enable;
		logic [1:0]  fast_source_select;
		logic        aux_switch_enable;
		logic [1:0]  aux_source_select;
		logic        input_term_master_on;
		logic [15:0] input_term_select_vec;
		logic [15:0] input_eq_select_vec;
		logic [1:0]  output_preemph_level;
		logic        output_term_on;
		logic        output_current_high;
	} tsw_cfg_t;

endpackage : tsw_pkg

// ---- tsw_strap_board.sv ----
// Board model of the strap pins that sit on the far side of the register bank
`timescale 1ns/100ps
module tsw_strap_board (
	input  wire tsw_pkg::tsw_strap_t rail_high_in, // One where a pin is tied to the 3.3 V rail
	output tsw_pkg::tsw_strap_t      strap_out     // Static levels seen by the switch
);
	////////////////////////////////////////////////////////////////////////////////
	// Straps are hard ties, so a pin on the rail is a steady one, grounded a zero
	// Limitation: no bounce or slow edges, since the bank synchronises them anyway
	assign strap_out = rail_high_in;
endmodule : tsw_strap_board

// ---- tsw_sync.sv ----
// Two-stage synchroniser for the strap pins
`timescale 1ns/100ps
module tsw_sync #(
	parameter int WIDTH = 8
) (
	input  wire logic             clock_in,
	input  wire logic             reset_in,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q;  // First stage, read only by the second
	logic [WIDTH-1:0] sync_q;  // Second stage, safe to use
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] sync_d;

	////////////////////////////////////////////////////////////////////////
	// Next values: a plain shift
	always_comb begin
		meta_d = async_in;
		sync_d = meta_q;
	end

	// Registers
	always_ff @(posedge clock_in or posedge reset_in) begin
		if (reset_in) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign sync_out = sync_q;

endmodule : tsw_sync
